/* File: rtl/bop_pkg.sv */
// Constants and types for the bit-operation and load datapath
package bop_pkg;
    localparam logic [9:0] ADDR_CMD = 10'h000;
    localparam logic [9:0] ADDR_STATUS = 10'h004;
    localparam logic [9:0] ADDR_FLAGS = 10'h008;
    localparam logic [9:0] ADDR_GPR_BASE = 10'h080;
    localparam logic [9:0] ADDR_GPR_LAST = 10'h0fc;
    localparam int OP_LSB = 0;
    localparam int OP_W = 5;
    localparam int RD_LSB = 5;
    localparam int RR_LSB = 10;
    localparam int REG_W = 5;
    localparam int BIT_LSB = 15;
    localparam int BIT_W = 3;
    localparam int IMM_LSB = 18;
    localparam int IMM_W = 8;
    localparam int PTR_LSB = 26;
    localparam int PTR_W = 2;
    localparam int IO_AW = 6;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ERR = 1;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] GPR_RESET = 8'h00;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [4:0] PTR_X_BASE = 5'h1a;
    localparam logic [4:0] PTR_Y_BASE = 5'h1c;
    localparam logic [4:0] PTR_Z_BASE = 5'h1e;
    typedef enum logic [4:0] {
        OP_IO_SET = 5'h00, OP_IO_CLR = 5'h01, OP_SHL = 5'h02, OP_SHR = 5'h03,
        OP_ROL = 5'h04, OP_ROR = 5'h05, OP_SAR = 5'h06, OP_SWAP = 5'h07,
        OP_BIT_STORE = 5'h08, OP_BIT_LOAD = 5'h09, OP_FLAG_SET = 5'h0a,
        OP_FLAG_CLR = 5'h0b, OP_COPY = 5'h0c, OP_PAIR_COPY = 5'h0d,
        OP_IMM = 5'h0e, OP_LD = 5'h0f, OP_LD_INC = 5'h10, OP_LD_DEC = 5'h11,
        OP_LD_OFS = 5'h12
    } op_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_FINISH = 2'b11
    } state_t;
endpackage

/* File: rtl/bop_unit.sv */
// Shift, rotate, bit transfer and flag set/clear unit
`timescale 1ns/1ns
module bop_unit (
    input wire bop_pkg::op_t i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_flags,
    input wire logic [2:0] i_bit,
    output logic [7:0] o_result,
    output logic [7:0] o_flags
);
    logic [7:0] res;
    logic cy;
    logic shift_op;

    always_comb begin
        res = i_a;
        cy = i_flags[bop_pkg::FLAG_C];
        shift_op = 1'b1;
        o_flags = i_flags;
        case (i_op)
            bop_pkg::OP_SHL: begin
                res = {i_a[6:0], 1'b0};
                cy = i_a[7];
            end
            bop_pkg::OP_SHR: begin
                res = {1'b0, i_a[7:1]};
                cy = i_a[0];
            end
            bop_pkg::OP_ROL: begin
                res = {i_a[6:0], i_flags[bop_pkg::FLAG_C]};
                cy = i_a[7];
            end
            bop_pkg::OP_ROR: begin
                res = {i_flags[bop_pkg::FLAG_C], i_a[7:1]};
                cy = i_a[0];
            end
            bop_pkg::OP_SAR: begin
                res = {i_a[7], i_a[7:1]};
                cy = i_a[0];
            end
            default: begin
                shift_op = 1'b0;
            end
        endcase
        if (shift_op) begin
            o_flags[bop_pkg::FLAG_C] = cy;
            o_flags[bop_pkg::FLAG_Z] = (res == 8'h00);
            o_flags[bop_pkg::FLAG_N] = res[7];
            o_flags[bop_pkg::FLAG_V] = res[7] ^ cy;
        end
        case (i_op)
            bop_pkg::OP_SWAP: res = {i_a[3:0], i_a[7:4]};
            bop_pkg::OP_BIT_STORE: o_flags[bop_pkg::FLAG_T] = i_a[i_bit];
            bop_pkg::OP_BIT_LOAD: res[i_bit] = i_flags[bop_pkg::FLAG_T];
            bop_pkg::OP_FLAG_SET: o_flags[i_bit] = 1'b1;
            bop_pkg::OP_FLAG_CLR: o_flags[i_bit] = 1'b0;
            default: res = res;
        endcase
        o_result = res;
    end
endmodule

/* File: rtl/bop_datapath.sv */
// Bit-operation and load datapath with Avalon-MM register access
// Functional notes
// - Set one I/O bit, no flags, 2 cycles
// - Clear one I/O bit, no flags, 2 cycles
// - Shift left, zero in, flags ZCNV, 1 cycle
// - Shift right, zero in, flags ZCNV, 1 cycle
// - Rotate left through carry, 1 cycle
// - Rotate right through carry, 1 cycle
// - Signed shift right keeps bit 7
// - Swap nibbles, flags unchanged, 1 cycle
// - Copy source register bit into T flag
// - Write T flag into destination bit
// - Overflow flag set or clear, 1 cycle
// - Half carry flag set or clear, 1 cycle
// - Signed test flag set or clear, 1 cycle
// - Load then increment pointer, 2 cycles
// - Decrement pointer then load, 2 cycles
// - Load at second/third pointer plus offset
// - All pointers support plain, increment, decrement loads
`timescale 1ns/1ns
module bop_datapath (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [15:0] o_mem_addr,
    output logic o_mem_rd,
    input wire logic [7:0] i_mem_rdata,
    output logic [5:0] o_io_addr,
    output logic o_io_rd,
    output logic o_io_wr,
    output logic [7:0] o_io_wdata,
    input wire logic [7:0] i_io_rdata,
    output logic [7:0] o_flags,
    output logic o_busy,
    output logic o_error
);
    logic [7:0] gpr_reg [32];
    logic [7:0] flags_reg;
    logic [31:0] cmd_reg;
    logic [31:0] cmd_next;
    bop_pkg::state_t state_reg;
    logic err_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic mem_rd_reg;
    logic [15:0] mem_addr_reg;
    logic [5:0] io_addr_reg;
    logic io_rd_reg;
    logic io_wr_reg;
    logic [7:0] io_wdata_reg;

    bop_pkg::op_t op;
    bop_pkg::op_t n_op;
    logic [4:0] rd_idx;
    logic [4:0] rr_idx;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [1:0] ptr_sel;
    logic [4:0] ptr_idx;
    logic [4:0] n_ptr_idx;
    logic [7:0] n_imm;
    logic [1:0] n_ptr_sel;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [15:0] ptr_val;
    logic [15:0] n_ptr_val;
    logic [15:0] n_mem_addr;
    logic n_legal;
    logic [7:0] alu_a;
    logic [7:0] alu_res;
    logic [7:0] alu_flags;
    logic bus_req;
    logic acc_ok;
    logic commit_wr;
    logic cmd_start;
    logic gpr_hit;
    logic [4:0] gpr_idx;
    logic [4:0] rd_pair;
    logic [4:0] rr_pair;
    logic rd_top;
    logic rd_low;
    logic c_flag;

    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        case (sel)
            bop_pkg::PTR_Y: ptr_base = bop_pkg::PTR_Y_BASE;
            bop_pkg::PTR_Z: ptr_base = bop_pkg::PTR_Z_BASE;
            default: ptr_base = bop_pkg::PTR_X_BASE;
        endcase
    endfunction

    function automatic logic is_load(input bop_pkg::op_t o);
        is_load = (o == bop_pkg::OP_LD) || (o == bop_pkg::OP_LD_INC) ||
            (o == bop_pkg::OP_LD_DEC) || (o == bop_pkg::OP_LD_OFS);
    endfunction

    function automatic logic is_io(input bop_pkg::op_t o);
        is_io = (o == bop_pkg::OP_IO_SET) || (o == bop_pkg::OP_IO_CLR);
    endfunction

    // Field decode of the running and the incoming command
    assign op = bop_pkg::op_t'(cmd_reg[bop_pkg::OP_LSB +: bop_pkg::OP_W]);
    assign rd_idx = cmd_reg[bop_pkg::RD_LSB +: bop_pkg::REG_W];
    assign rr_idx = cmd_reg[bop_pkg::RR_LSB +: bop_pkg::REG_W];
    assign bit_sel = cmd_reg[bop_pkg::BIT_LSB +: bop_pkg::BIT_W];
    assign imm = cmd_reg[bop_pkg::IMM_LSB +: bop_pkg::IMM_W];
    assign ptr_sel = cmd_reg[bop_pkg::PTR_LSB +: bop_pkg::PTR_W];
    assign n_op = bop_pkg::op_t'(cmd_next[bop_pkg::OP_LSB +: bop_pkg::OP_W]);
    assign n_imm = cmd_next[bop_pkg::IMM_LSB +: bop_pkg::IMM_W];
    assign n_ptr_sel = cmd_next[bop_pkg::PTR_LSB +: bop_pkg::PTR_W];
    assign ptr_idx = ptr_base(ptr_sel);
    assign n_ptr_idx = ptr_base(n_ptr_sel);
    assign rd_val = gpr_reg[rd_idx];
    assign rr_val = gpr_reg[rr_idx];
    assign ptr_val = {gpr_reg[ptr_idx + 5'd1], gpr_reg[ptr_idx]};
    assign n_ptr_val = {gpr_reg[n_ptr_idx + 5'd1], gpr_reg[n_ptr_idx]};
    assign rd_pair = {rd_idx[4:1], 1'b0};
    assign rr_pair = {rr_idx[4:1], 1'b0};
    assign rd_top = rd_val[7];
    assign rd_low = rd_val[0];
    assign c_flag = flags_reg[bop_pkg::FLAG_C];

    // Byte-lane merge of a command write
    always_comb begin
        cmd_next = cmd_reg;
        for (int i = 0; i < 4; i++) begin
            if (i_avs_byteenable[i]) begin
                cmd_next[i*8 +: 8] = i_avs_writedata[i*8 +: 8];
            end
        end
    end

    // Offset loads only on the second and third pointer
    assign n_legal = (n_op <= bop_pkg::OP_LD_OFS) &&
        !(is_load(n_op) && (n_ptr_sel > bop_pkg::PTR_Z)) &&
        !((n_op == bop_pkg::OP_LD_OFS) && (n_ptr_sel == bop_pkg::PTR_X));

    always_comb begin
        case (n_op)
            bop_pkg::OP_LD_DEC: n_mem_addr = n_ptr_val - 16'h0001;
            bop_pkg::OP_LD_OFS: n_mem_addr = n_ptr_val + {8'h00, n_imm};
            default: n_mem_addr = n_ptr_val;
        endcase
    end

    assign alu_a = (op == bop_pkg::OP_BIT_STORE) ? rr_val : rd_val;

    bop_unit u_unit (
        .i_op(op),
        .i_a(alu_a),
        .i_flags(flags_reg),
        .i_bit(bit_sel),
        .o_result(alu_res),
        .o_flags(alu_flags)
    );

    // Avalon slave: one wait cycle, writes held off while busy
    assign bus_req = i_avs_read | i_avs_write;
    assign acc_ok = !(i_avs_write && (state_reg != bop_pkg::ST_IDLE));
    assign commit_wr = i_avs_write && !wait_reg;
    assign cmd_start = commit_wr && (i_avs_address == bop_pkg::ADDR_CMD);
    assign gpr_hit = (i_avs_address >= bop_pkg::ADDR_GPR_BASE) &&
        (i_avs_address <= bop_pkg::ADDR_GPR_LAST) && (i_avs_address[1:0] == 2'b00);
    assign gpr_idx = i_avs_address[6:2];

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (i_avs_address)
            bop_pkg::ADDR_CMD: rdata_next = cmd_reg;
            bop_pkg::ADDR_STATUS: begin
                rdata_next[bop_pkg::STAT_BUSY] = state_reg[0];
                rdata_next[bop_pkg::STAT_ERR] = err_reg;
            end
            bop_pkg::ADDR_FLAGS: rdata_next[7:0] = flags_reg;
            default: begin
                if (gpr_hit) begin
                    rdata_next[7:0] = gpr_reg[gpr_idx];
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !(wait_reg && bus_req && acc_ok);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wait_reg && i_avs_read) begin
            rdata_reg <= rdata_next;
        end
    end

    // Sequencer
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            state_reg <= bop_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                bop_pkg::ST_IDLE: begin
                    if (cmd_start && n_legal) begin
                        state_reg <= bop_pkg::ST_EXEC;
                    end
                end
                bop_pkg::ST_EXEC: begin
                    if (is_load(op) || is_io(op)) begin
                        state_reg <= bop_pkg::ST_FINISH;
                    end else begin
                        state_reg <= bop_pkg::ST_IDLE;
                    end
                end
                bop_pkg::ST_FINISH: state_reg <= bop_pkg::ST_IDLE;
                default: state_reg <= bop_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cmd_reg <= bop_pkg::CMD_RESET;
            err_reg <= 1'b0;
        end else if (cmd_start) begin
            cmd_reg <= cmd_next;
            err_reg <= !n_legal;
        end
    end

    // Data memory read strobe, issued as the command is taken
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            mem_rd_reg <= 1'b0;
            mem_addr_reg <= 16'h0000;
        end else if (cmd_start && n_legal && is_load(n_op)) begin
            mem_rd_reg <= 1'b1;
            mem_addr_reg <= n_mem_addr;
        end else begin
            mem_rd_reg <= 1'b0;
        end
    end

    // I/O read in the first cycle, modified write in the second
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            io_addr_reg <= 6'h00;
            io_rd_reg <= 1'b0;
            io_wr_reg <= 1'b0;
            io_wdata_reg <= 8'h00;
        end else if (cmd_start && n_legal && is_io(n_op)) begin
            io_addr_reg <= n_imm[bop_pkg::IO_AW-1:0];
            io_rd_reg <= 1'b1;
            io_wr_reg <= 1'b0;
        end else if (state_reg == bop_pkg::ST_EXEC && is_io(op)) begin
            io_rd_reg <= 1'b0;
            io_wr_reg <= 1'b1;
            if (op == bop_pkg::OP_IO_SET) begin
                io_wdata_reg <= i_io_rdata | (8'h01 << bit_sel);
            end else begin
                io_wdata_reg <= i_io_rdata & ~(8'h01 << bit_sel);
            end
        end else begin
            io_rd_reg <= 1'b0;
            io_wr_reg <= 1'b0;
        end
    end

    // Register file
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            for (int i = 0; i < 32; i++) begin
                gpr_reg[i] <= bop_pkg::GPR_RESET;
            end
        end else begin
            if (commit_wr && gpr_hit && i_avs_byteenable[0]) begin
                gpr_reg[gpr_idx] <= i_avs_writedata[7:0];
            end
            if (state_reg == bop_pkg::ST_EXEC) begin
                case (op)
                    bop_pkg::OP_SHL, bop_pkg::OP_SHR, bop_pkg::OP_ROL, bop_pkg::OP_ROR,
                    bop_pkg::OP_SAR, bop_pkg::OP_SWAP, bop_pkg::OP_BIT_LOAD: begin
                        gpr_reg[rd_idx] <= alu_res;
                    end
                    bop_pkg::OP_COPY: gpr_reg[rd_idx] <= rr_val;
                    bop_pkg::OP_PAIR_COPY: begin
                        gpr_reg[rd_pair] <= gpr_reg[rr_pair];
                        gpr_reg[rd_pair + 5'd1] <= gpr_reg[rr_pair + 5'd1];
                    end
                    bop_pkg::OP_IMM: gpr_reg[rd_idx] <= imm;
                    bop_pkg::OP_LD_INC: begin
                        {gpr_reg[ptr_idx + 5'd1], gpr_reg[ptr_idx]} <= ptr_val + 16'h0001;
                    end
                    bop_pkg::OP_LD_DEC: begin
                        {gpr_reg[ptr_idx + 5'd1], gpr_reg[ptr_idx]} <= mem_addr_reg;
                    end
                    default: gpr_reg[0] <= gpr_reg[0];
                endcase
            end
            if (state_reg == bop_pkg::ST_FINISH && is_load(op)) begin
                gpr_reg[rd_idx] <= i_mem_rdata;
            end
        end
    end

    // Flags: loads, copies and I/O bit ops leave them alone
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            flags_reg <= bop_pkg::FLAGS_RESET;
        end else if (commit_wr && i_avs_address == bop_pkg::ADDR_FLAGS && i_avs_byteenable[0]) begin
            flags_reg <= i_avs_writedata[7:0];
        end else if (state_reg == bop_pkg::ST_EXEC) begin
            flags_reg <= alu_flags;
        end
    end

    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_mem_addr = mem_addr_reg;
    assign o_mem_rd = mem_rd_reg;
    assign o_io_addr = io_addr_reg;
    assign o_io_rd = io_rd_reg;
    assign o_io_wr = io_wr_reg;
    assign o_io_wdata = io_wdata_reg;
    assign o_flags = flags_reg;
    assign o_busy = state_reg[0];
    assign o_error = err_reg;

    // Checks
    a_io_set_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && op == bop_pkg::OP_IO_SET)
        |=> o_io_wr && o_io_wdata[bit_sel] && $stable(flags_reg) ##1 !o_busy)
        else $error("io bit set wrong");
    a_io_clear_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && op == bop_pkg::OP_IO_CLR)
        |=> o_io_wr && !o_io_wdata[bit_sel] && $stable(flags_reg) ##1 !o_io_wr)
        else $error("io bit clear wrong");
    a_shift_left: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && op == bop_pkg::OP_SHL)
        |=> rd_val == ($past(rd_val) << 1) && c_flag == $past(rd_top) && !o_busy)
        else $error("shift left wrong");
    a_shift_right: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && op == bop_pkg::OP_SHR)
        |=> rd_val == ($past(rd_val) >> 1) && c_flag == $past(rd_low))
        else $error("shift right wrong");
    a_rotate_left: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && op == bop_pkg::OP_ROL)
        |=> rd_val[0] == $past(c_flag) && c_flag == $past(rd_top))
        else $error("rotate left wrong");
    a_nibble_swap: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && op == bop_pkg::OP_SWAP)
        |=> rd_val == (($past(rd_val) << 4) | ($past(rd_val) >> 4)) && $stable(flags_reg))
        else $error("nibble swap wrong");
    a_load_post_inc: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && op == bop_pkg::OP_LD_INC && rd_pair != ptr_idx)
        |-> o_mem_rd && o_mem_addr == ptr_val ##1 ptr_val == o_mem_addr + 16'h0001
        ##1 rd_val == $past(i_mem_rdata) && !o_busy)
        else $error("post increment load wrong");
    a_load_pre_dec: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && op == bop_pkg::OP_LD_DEC)
        |-> o_mem_addr == ptr_val - 16'h0001 ##1 ptr_val == o_mem_addr)
        else $error("pre decrement load wrong");
    a_load_no_flags: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg != bop_pkg::ST_IDLE && is_load(op)) |=> $stable(flags_reg))
        else $error("load changed flags");
    a_flag_set_one: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && op == bop_pkg::OP_FLAG_SET)
        |=> flags_reg[bit_sel] && ((flags_reg ^ $past(flags_reg)) & ~(8'h01 << bit_sel)) == 8'h00)
        else $error("flag set touched other flags");
    a_io_read_strobe: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_reg == bop_pkg::ST_EXEC && is_io(op)) |-> o_io_rd && !o_io_wr)
        else $error("io read strobe missing");
    a_write_held: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_busy && i_avs_write) |-> o_avs_waitrequest)
        else $error("write accepted while busy");
endmodule

/* File: bench/bop_mem_model.sv */
// Data memory and I/O register space model facing the datapath
`timescale 1ns/1ns
module bop_mem_model (
    input wire logic i_clk_sys,
    input wire logic [15:0] i_mem_addr,
    input wire logic i_mem_rd,
    output logic [7:0] o_mem_rdata,
    input wire logic [5:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata
);
    logic [7:0] io_q [64];
    initial begin
        o_mem_rdata = 8'h00;
        for (int i = 0; i < 64; i++) begin
            io_q[i] = 8'(i * 37 + 1);
        end
    end
    // Read data valid only in the cycle after the strobe, toggles otherwise
    always @(posedge i_clk_sys) begin
        if (i_mem_rd) begin
            o_mem_rdata <= i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ 8'h3c;
        end else begin
            o_mem_rdata <= ~o_mem_rdata;
        end
        if (i_io_wr) begin
            io_q[i_io_addr] <= i_io_wdata;
        end
    end
    assign o_io_rdata = io_q[i_io_addr];
endmodule

/* File: bench/bop_datapath_tb.sv */
// Self-checking testbench for the bit-operation and load datapath
`timescale 1ns/1ns
module bop_datapath_tb;
    logic clk, rstn, rd, wr, waitreq, mem_rd, io_rd, io_wr, busy, err;
    logic [9:0] addr;
    logic [31:0] wdata, rdata;
    logic [15:0] mem_addr;
    logic [7:0] mem_rdata, io_rdata, io_wdata, flags, xf;
    logic [5:0] io_addr;
    logic [7:0] gpr [32];
    logic [7:0] xio [64];
    int n_mismatch = 0, samples_checked = 0, cycles = 0, busy_cnt = 0, seed = 51;

    bop_datapath dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .i_mem_rdata(mem_rdata),
        .o_io_addr(io_addr), .o_io_rd(io_rd), .o_io_wr(io_wr), .o_io_wdata(io_wdata),
        .i_io_rdata(io_rdata), .o_flags(flags), .o_busy(busy), .o_error(err));
    bop_mem_model mem_u (.i_clk_sys(clk), .i_mem_addr(mem_addr), .i_mem_rd(mem_rd),
        .o_mem_rdata(mem_rdata), .i_io_addr(io_addr), .i_io_wr(io_wr),
        .i_io_wdata(io_wdata), .o_io_rdata(io_rdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (busy === 1'b1) busy_cnt++;
        if (cycles == 60000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Avalon master: hold request until waitrequest sampled low
    task bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
        int t;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (waitreq !== 1'b0 && t < 300);
        q = rdata;
        if (t >= 300) n_mismatch++;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task rdchk(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task wait_idle(output logic [31:0] q);
        int t;
        t = 0;
        do bus(1'b0, bop_pkg::ADDR_STATUS, 32'h0, q); while (q[0] !== 1'b0 && t++ < 50);
        if (t > 50) n_mismatch++;
    endtask
    function automatic logic [7:0] mem_f(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h3c;
    endfunction

    task one_op(input int op, input int n);
        logic [31:0] cmd, q;
        logic [4:0] d, s;
        logic [2:0] b;
        logic [7:0] im, a;
        logic [1:0] p;
        logic [15:0] pa;
        int pb, want;
        cmd = $random(seed);
        p = 2'(cmd[26] + ((op == 18) ? 1 : cmd[27]));
        cmd[31:26] = {4'h0, p};
        cmd[4:0] = 5'(op);
        if (op == 13) {cmd[10], cmd[5]} = 2'b00;
        if (op == 10 || op == 11) cmd[17:15] = 3'(n / 19);
        d = cmd[9:5];
        s = cmd[14:10];
        b = cmd[17:15];
        im = cmd[25:18];
        xf = $random(seed);
        bus(1'b1, bop_pkg::ADDR_FLAGS, {24'h0, xf}, q);
        pb = 26 + 2 * p;
        pa = {gpr[pb + 1], gpr[pb]};
        a = gpr[d];
        want = 1;
        case (op)
            0: begin want = 2; xio[im[5:0]][b] = 1'b1; end
            1: begin want = 2; xio[im[5:0]][b] = 1'b0; end
            2: begin xf[0] = a[7]; a = {a[6:0], 1'b0}; end
            3: begin xf[0] = a[0]; a = {1'b0, a[7:1]}; end
            4: begin a = {a[6:0], xf[0]}; xf[0] = gpr[d][7]; end
            5: begin a = {xf[0], a[7:1]}; xf[0] = gpr[d][0]; end
            6: begin xf[0] = a[0]; a = {a[7], a[7:1]}; end
            7: a = {a[3:0], a[7:4]};
            8: xf[6] = gpr[s][b];
            9: a[b] = xf[6];
            10: xf[b] = 1'b1;
            11: xf[b] = 1'b0;
            12: a = gpr[s];
            13: begin gpr[d + 1] = gpr[s + 1]; a = gpr[s]; end
            14: a = im;
            default: begin
                want = 2;
                if (op == 17) pa--;
                a = mem_f((op == 18) ? pa + 16'(im) : pa);
                if (op == 16) pa++;
                {gpr[pb + 1], gpr[pb]} = pa;
            end
        endcase
        if (op >= 2 && op <= 6) begin
            xf[1] = (a == 8'h00);
            xf[2] = a[7];
            xf[3] = a[7] ^ xf[0];
        end
        if (op > 1 && op != 8 && op != 10 && op != 11) gpr[d] = a;
        busy_cnt = 0;
        bus(1'b1, bop_pkg::ADDR_CMD, cmd, q);
        wait_idle(q);
        chk(q, 32'h0);
        chk(busy_cnt, want);
        chk({24'h0, flags}, {24'h0, xf});
        rdchk(bop_pkg::ADDR_FLAGS, {24'h0, xf});
        for (int i = 0; i < 32; i++) begin
            rdchk(bop_pkg::ADDR_GPR_BASE + 10'(4 * i), {24'h0, gpr[i]});
        end
        if (op < 2) chk({24'h0, mem_u.io_q[im[5:0]]}, {24'h0, xio[im[5:0]]});
    endtask

    initial begin
        logic [31:0] q;
        rstn = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 10'h000;
        wdata = 32'h0;
        for (int i = 0; i < 64; i++) xio[i] = 8'(i * 37 + 1);
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rdchk(bop_pkg::ADDR_FLAGS, 32'h0);
        rdchk(bop_pkg::ADDR_GPR_BASE + 10'h014, 32'h0);
        rdchk(10'h040, 32'h0);
        rdchk(bop_pkg::ADDR_STATUS, 32'h0);
        for (int i = 0; i < 32; i++) begin
            gpr[i] = $random(seed);
            bus(1'b1, bop_pkg::ADDR_GPR_BASE + 10'(4 * i), {24'h0, gpr[i]}, q);
        end
        bus(1'b1, bop_pkg::ADDR_CMD, 32'h0000_0013, q);
        wait_idle(q);
        chk(q, 32'h2);
        chk({31'h0, err}, 32'h1);
        for (int n = 0; n < 300; n++) one_op(n % 19, n);
        // Flags write right behind a load must stall, then land
        bus(1'b1, bop_pkg::ADDR_CMD, 32'h0000_002f, q);
        bus(1'b1, bop_pkg::ADDR_FLAGS, 32'h0000_00a5, q);
        rdchk(bop_pkg::ADDR_FLAGS, 32'h0000_00a5);
        rdchk(bop_pkg::ADDR_GPR_BASE + 10'h004, {24'h0, mem_f({gpr[27], gpr[26]})});
        tally_and_finish();
    end
endmodule
